// >>> tcpd_cc_model.sv
// port controller stand-in driving the decoder pins
// pins move one clk edge after the logical inputs
`timescale 1ns/1ps
module tcpd_cc_model
	import tcpd_pkg::*;
(
	input wire logic clk,
	input wire logic pol,
	input wire logic sch,
	input wire logic [2:0] att,
	input wire logic [1:0] ori,
	output tcpd_pins_type pins
);
	logic [1:0] a, b;
	assign a = att[2:1] & ~ori;
	assign b = att[2:1] & ori;
	initial pins = '0;
	// unused scheme pins carry a misleading pattern, not idle zeros
	always @(posedge clk) begin
		pins.attach_in <= {sch ? b : att[2:1], att[0]} ^ {3{pol}};
		pins.plug_orientation_in <= (sch ? ~ori : ori) ^ {2{pol}};
		pins.orient_a_attach_in <= (sch ? a : b) ^ {2{pol}};
		pins.orient_b_attach_in <= (sch ? b : a) ^ {2{pol}};
		pins.attach_polarity_strap <= pol;
		pins.scheme_select_strap <= sch;
	end
endmodule

// >>> tcpd_pkg.sv
// constants and carrier types for the type-c phy enable decoder
// assumes a single core clock domain and a plain one-cycle register port
package tcpd_pkg;

	localparam int TCPD_NUM_ATTACH = 3;
	localparam int TCPD_NUM_TC = 2;
	localparam int TCPD_NUM_PHY = 5;
	localparam int TCPD_ADDR_W = 8;
	localparam int TCPD_DATA_W = 32;

	// phy enable vector layout
	localparam int TCPD_PHY_LEGACY_BIT = 0;
	localparam int TCPD_PHY_A_LSB = 1;
	localparam int TCPD_PHY_B_LSB = 3;

	// register byte offsets
	localparam logic [7:0] TCPD_CTRL_OFS = 8'h00;
	localparam logic [7:0] TCPD_FORCE_OFF_OFS = 8'h04;
	localparam logic [7:0] TCPD_STATUS_OFS = 8'h08;
	localparam logic [7:0] TCPD_PINS_OFS = 8'h0C;

	// ctrl fields
	localparam int TCPD_CTRL_EN_BIT = 0;
	localparam logic TCPD_CTRL_EN_RST = 1'h1;
	localparam logic [4:0] TCPD_FORCE_OFF_RST = 5'h00;

	// pins readback field positions
	localparam int TCPD_PINS_ATT_LSB = 0;
	localparam int TCPD_PINS_ORIENT_LSB = 3;
	localparam int TCPD_PINS_MUXA_LSB = 5;
	localparam int TCPD_PINS_MUXB_LSB = 7;
	localparam int TCPD_PINS_POL_BIT = 9;
	localparam int TCPD_PINS_SCHEME_BIT = 10;

	typedef enum logic [1:0] {
		TCPD_SCHEME_SEPARATE = 2'h1,
		TCPD_SCHEME_PER_ORIENT = 2'h2
	} tcpd_scheme_type;

	typedef struct packed {
		logic [TCPD_NUM_ATTACH-1:0] attach_in;
		logic [TCPD_NUM_TC-1:0] plug_orientation_in;
		logic [TCPD_NUM_TC-1:0] orient_a_attach_in;
		logic [TCPD_NUM_TC-1:0] orient_b_attach_in;
		logic attach_polarity_strap;
		logic scheme_select_strap;
	} tcpd_pins_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [TCPD_ADDR_W-1:0] addr;
		logic [TCPD_DATA_W-1:0] wdata;
	} tcpd_bus_req_type;

endpackage

// >>> tcpd_top.sv
// type-c attach / orientation decode into superspeed phy enables
// assumes pins are asynchronous to clk and the register master never
// asserts read and write together
`timescale 1ns/1ps

module tcpd_top
	import tcpd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire tcpd_pins_type pins,
	input wire tcpd_bus_req_type bus_req,
	output logic [TCPD_DATA_W-1:0] rd_data,
	output logic [TCPD_NUM_PHY-1:0] phy_en
);

	localparam int PINS_W = $bits(tcpd_pins_type);

	tcpd_pins_type meta_r;
	tcpd_pins_type sync_r;
	logic ctrl_en_r;
	logic [TCPD_NUM_PHY-1:0] force_off_r;
	logic [TCPD_NUM_PHY-1:0] phy_en_r;
	logic [TCPD_NUM_PHY-1:0] phy_en_nxt;
	logic [TCPD_DATA_W-1:0] rd_data_r;
	logic [TCPD_DATA_W-1:0] rd_data_nxt;
	logic [TCPD_NUM_ATTACH-1:0] attach_act;
	logic [TCPD_NUM_TC-1:0] orient_is_b;
	logic [TCPD_NUM_TC-1:0] mux_a_act;
	logic [TCPD_NUM_TC-1:0] mux_b_act;
	tcpd_scheme_type scheme;

	// two-flop synchroniser; straps too, since they may settle after reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= pins;
			sync_r <= meta_r;
		end
	end

	// polarity normalisation: attach, orientation and mux inputs become active high; straps are used as is
	always_comb begin
		attach_act = sync_r.attach_in ^ {TCPD_NUM_ATTACH{sync_r.attach_polarity_strap}};
		orient_is_b = sync_r.plug_orientation_in
			^ {TCPD_NUM_TC{sync_r.attach_polarity_strap}};
		mux_a_act = sync_r.orient_a_attach_in
			^ {TCPD_NUM_TC{sync_r.attach_polarity_strap}};
		mux_b_act = sync_r.orient_b_attach_in
			^ {TCPD_NUM_TC{sync_r.attach_polarity_strap}};
		scheme = sync_r.scheme_select_strap ? TCPD_SCHEME_PER_ORIENT
			: TCPD_SCHEME_SEPARATE;
	end

	// the legacy port has one phy and is driven by its attach in both schemes
	always_comb begin
		phy_en_nxt = '0;
		phy_en_nxt[TCPD_PHY_LEGACY_BIT] = attach_act[0];
		for (int i = 0; i < TCPD_NUM_TC; i++) begin
			case (scheme)
				TCPD_SCHEME_SEPARATE: begin
					phy_en_nxt[TCPD_PHY_A_LSB+i] = attach_act[i+1] & ~orient_is_b[i];
					phy_en_nxt[TCPD_PHY_B_LSB+i] = attach_act[i+1] & orient_is_b[i];
				end
				TCPD_SCHEME_PER_ORIENT: begin
					phy_en_nxt[TCPD_PHY_A_LSB+i] = mux_a_act[i];
					phy_en_nxt[TCPD_PHY_B_LSB+i] = mux_b_act[i];
				end
				default: begin
					phy_en_nxt[TCPD_PHY_A_LSB+i] = 1'h0;
					phy_en_nxt[TCPD_PHY_B_LSB+i] = 1'h0;
				end
			endcase
		end
		// software gating only removes power, it never forces a phy on
		if (!ctrl_en_r) begin
			phy_en_nxt = '0;
		end
		phy_en_nxt = phy_en_nxt & ~force_off_r;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phy_en_r <= '0;
		end else begin
			phy_en_r <= phy_en_nxt;
		end
	end

	// control registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_en_r <= TCPD_CTRL_EN_RST;
			force_off_r <= TCPD_FORCE_OFF_RST;
		end else if (bus_req.wr) begin
			case (bus_req.addr)
				TCPD_CTRL_OFS: begin
					ctrl_en_r <= bus_req.wdata[TCPD_CTRL_EN_BIT];
				end
				TCPD_FORCE_OFF_OFS: begin
					force_off_r <= bus_req.wdata[TCPD_NUM_PHY-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_data_nxt = '0;
		if (bus_req.rd) begin
			case (bus_req.addr)
				TCPD_CTRL_OFS: begin
					rd_data_nxt[TCPD_CTRL_EN_BIT] = ctrl_en_r;
				end
				TCPD_FORCE_OFF_OFS: begin
					rd_data_nxt[TCPD_NUM_PHY-1:0] = force_off_r;
				end
				TCPD_STATUS_OFS: begin
					rd_data_nxt[TCPD_NUM_PHY-1:0] = phy_en_r;
				end
				TCPD_PINS_OFS: begin
					rd_data_nxt[PINS_W-1:0] = {sync_r.scheme_select_strap,
						sync_r.attach_polarity_strap, sync_r.orient_b_attach_in,
						sync_r.orient_a_attach_in, sync_r.plug_orientation_in,
						sync_r.attach_in};
				end
				default: begin
					rd_data_nxt = '0;
				end
			endcase
		end
	end

	// read data holds only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_r <= '0;
		end else begin
			rd_data_r <= rd_data_nxt;
		end
	end

	assign rd_data = rd_data_r;
	assign phy_en = phy_en_r;

endmodule

// >>> tcpd_top_bench.sv
// bench: cc model drives pins, tasks drive the register port
// assumes one 125 MHz clock
`timescale 1ns/1ps
module tcpd_top_bench;
	import tcpd_pkg::*;
	logic clk = 1'b0, rst_b = 1'b0, pol = 1'b0, sch = 1'b0;
	logic [2:0] att = 3'h0;
	logic [1:0] ori = 2'h0;
	tcpd_pins_type pins;
	tcpd_bus_req_type bus_req = '0;
	logic [31:0] rd_data;
	logic [4:0] phy_en, e;
	logic [7:0] ra [5] = '{8'h08, 8'h0C, 8'h04, 8'h00, 8'h10};
	logic [11:0] rx [5] = '{12'h000, 12'h678, 12'h001, 12'h000, 12'h000};
	int n_mismatch = 0, checks = 0, cyc = 0;
	always #4 clk = ~clk;
	tcpd_cc_model tcpd_cc_model_inst (.clk(clk), .pol(pol), .sch(sch), .att(att), .ori(ori),
		.pins(pins));
	tcpd_top tcpd_top_inst (.clk(clk), .rst_b(rst_b), .pins(pins), .bus_req(bus_req),
		.rd_data(rd_data), .phy_en(phy_en));
	task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
		checks++;
		if (x !== g) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h got %h", nm, x, g);
		end
	endtask
	task automatic acc(logic w, logic [7:0] ad, logic [31:0] d);
		@(posedge clk);
		bus_req <= '{wr: w, rd: !w, addr: ad, wdata: d};
		@(posedge clk);
		bus_req <= '0;
		#1;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			results();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 128; i++) begin
			@(posedge clk);
			{pol, sch, att, ori} <= i[6:0];
			e = {i[4:3] & i[1:0], i[4:3] & ~i[1:0], i[2]};
			repeat (5) @(posedge clk);
			#1;
			chk("phy_en", e, phy_en);
		end
		acc(1'b1, TCPD_FORCE_OFF_OFS, 32'h1);
		acc(1'b0, TCPD_STATUS_OFS, 32'h0);
		chk("status", 32'h18, rd_data);
		acc(1'b1, TCPD_CTRL_OFS, 32'h0);
		for (int k = 0; k < 5; k++) begin
			acc(1'b0, ra[k], 32'h0);
			chk("reg", {20'h0, rx[k]}, rd_data);
		end
		results();
	end
endmodule

// >>> tcpd_top_chk.sv
// decode and register port assertions for tcpd_top
// decode checks stop once any register write is seen
`timescale 1ns/1ps
module tcpd_top_chk
	import tcpd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire tcpd_pins_type pins,
	input wire tcpd_bus_req_type bus_req,
	input wire logic [TCPD_DATA_W-1:0] rd_data,
	input wire logic [TCPD_NUM_PHY-1:0] phy_en
);
	tcpd_pins_type p1_r, p2_r, p_r;
	logic [2:0] cnt_r;
	logic wr_r, ok, pl, sc;
	logic [2:0] a;
	logic [1:0] o;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{p1_r, p2_r, p_r, cnt_r, wr_r} <= '0;
		end else begin
			{p1_r, p2_r, p_r} <= {pins, p1_r, p2_r};
			cnt_r <= cnt_r + {2'h0, cnt_r != 3'h7};
			wr_r <= wr_r | bus_req.wr;
		end
	end
	assign ok = cnt_r == 3'h7 && !wr_r;
	assign pl = p_r.attach_polarity_strap;
	assign sc = p_r.scheme_select_strap;
	assign a = p_r.attach_in ^ {3{pl}};
	assign o = p_r.plug_orientation_in ^ {2{pl}};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_LEG: assert property (ok |-> phy_en[0] == a[0])
		else $error("legacy phy");
	AST_S1A: assert property (ok && !sc |-> phy_en[2:1] == (a[2:1] & ~o))
		else $error("phy a s1");
	AST_S1B: assert property (ok && !sc |-> phy_en[4:3] == (a[2:1] & o))
		else $error("phy b s1");
	AST_S2A: assert property (ok && sc |-> phy_en[2:1] == (p_r.orient_a_attach_in ^ {2{pl}}))
		else $error("phy a s2");
	AST_S2B: assert property (ok && sc |-> phy_en[4:3] == (p_r.orient_b_attach_in ^ {2{pl}}))
		else $error("phy b s2");
	AST_SYNC: assert property (ok && !$stable(phy_en) |-> p_r != $past(p_r))
		else $error("early phy change");
	AST_RDZ: assert property (cnt_r != 3'h0 && !$past(bus_req.rd) |-> rd_data == '0)
		else $error("rd_data not idle");
	AST_STAT: assert property (bus_req.rd && bus_req.addr == TCPD_STATUS_OFS
		|=> rd_data[4:0] == $past(phy_en)) else $error("status");
	COV_S1: cover property (ok && !sc && phy_en[1]);
	COV_S2: cover property (ok && sc && phy_en[3]);
	COV_WR: cover property (bus_req.wr);
endmodule
bind tcpd_top tcpd_top_chk tcpd_top_chk_inst (.clk(clk), .rst_b(rst_b), .pins(pins),
	.bus_req(bus_req), .rd_data(rd_data), .phy_en(phy_en));
